// ==== dv/serial_port_i2c_master_tx_tb_top.sv ====
/*
 Self-checking bench: AXI4-Lite master tasks, slave model on the wires.
 Assumes the register map of ssp_cfg.svh and a 25 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssp_cfg.svh"

module serial_port_i2c_master_tx_tb_top;
  logic clk_i, rst_n_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, sck_i, sdi_i, ack_en, sda_low, stable_err;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, sdo_o, irq_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, rx_byte, d1, d2, per;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  int n_errors, cmp_count, k;
  wire scl_w = !scl_oe_o;
  wire sda_w = !sda_oe_o && !sda_low;

  ssp_i2c_master_tx u_ssp_i2c_master_tx (.clk_i, .rst_n_i, .ce_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o,
    .sck_i, .sdi_i, .sdo_o, .irq_o);
  ssp_i2c_slave_model u_ssp_i2c_slave_model (.clk_i, .rst_n_i, .scl_i(scl_w), .sda_i(sda_w),
    .ack_en_i(ack_en), .sda_low_o(sda_low), .rx_byte_o(rx_byte), .stable_err_o(stable_err));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = !clk_i;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Request stands until the rising edge that samples ready high; a lost answer counts
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= {24'h000000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (s_axi_awready_o !== 1'b1 && i < 100);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i  <= 1'b0;
    do begin
      @(posedge clk_i);
      i++;
    end while (s_axi_bvalid_o !== 1'b1 && i < 200);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (s_axi_bvalid_o !== 1'b1) n_errors++;
  endtask

  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (s_axi_arready_o !== 1'b1 && i < 100);
    s_axi_arvalid_i <= 1'b0;
    do begin
      @(posedge clk_i);
      i++;
    end while (s_axi_rvalid_o !== 1'b1 && i < 200);
    rd  = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (s_axi_rvalid_o !== 1'b1) n_errors++;
  endtask

  // Bounded wait for the end of a byte, then clear both flags
  task automatic byte_end;
    int i;
    for (i = 0; i < 3000 && irq_o !== 1'b1; i++) @(negedge clk_i);
    chk("irq", 1, irq_o);
    wr(`SSP_OFF_IRQ_STAT, 8'h03);
  endtask

  initial begin
    #400000 n_errors++;
    stop_test();
  end

  initial begin
    {ce_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 5'h10;
    {s_axi_arvalid_i, s_axi_rready_i, sck_i, sdi_i, ack_en} = 5'h00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
    s_axi_wstrb_i = 4'hF;
    n_errors = 0; cmp_count = 0;
    k = $urandom(7454);
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdr(`SSP_OFF_BRG); chk("brg", 32'h09, rd);
    rdr(8'h1C); chk("resp", `SSP_RESP_SLVERR, rsp);
    wr(8'h1C, 8'h00); chk("bresp", `SSP_RESP_SLVERR, rsp);
    wr(`SSP_OFF_STAT, 8'hFF); rdr(`SSP_OFF_STAT); chk("stat", 32'hC0, rd);
    wr(`SSP_OFF_STAT, 8'h00);
    per = 8'h03 + 8'($urandom % 4);
    wr(`SSP_OFF_BRG, per); wr(`SSP_OFF_IRQ_MASK, 8'h01);
    // Acknowledged byte, then one left unanswered
    for (k = 0; k < 2; k++) begin
      ack_en <= (k == 0); d1 = 8'($urandom);
      wr(`SSP_OFF_BUF, d1); rdr(`SSP_OFF_STAT); chk("bf", 32'h01, rd);
      byte_end();
      chk("rx", d1, rx_byte);
      rdr(`SSP_OFF_CTRL2); chk("ack", k ? 32'h40 : 32'h00, rd);
      rdr(`SSP_OFF_STAT); chk("bf", 32'h00, rd);
      chk("scl_hold", 1, scl_oe_o);
      repeat (2) @(posedge clk_i);
      chk("irq_clr", 0, irq_o);
    end
    chk("sda_stable", 0, stable_err);
    // Late second write is dropped, early one overwrites
    for (k = 0; k < 2; k++) begin
      d1 = 8'($urandom); d2 = ~d1;
      wr(`SSP_OFF_BUF, d1);
      if (k == 0) repeat (12) @(posedge clk_i);
      wr(`SSP_OFF_BUF, d2);
      rdr(`SSP_OFF_BUF); chk("buf", k ? d2 : d1, rd);
      rdr(`SSP_OFF_IRQ_STAT); chk("write_collision_flag", 32'h02, rd & 32'h02);
      byte_end();
      if (k == 0) chk("rx", d1, rx_byte);
    end
    // SPI slave byte: random in, fixed corner pattern out, clock idles low
    wr(`SSP_OFF_CTRL1, 8'h01);
    d1 = 8'($urandom);
    d2 = 8'hA5;
    wr(`SSP_OFF_BUF, d2);
    for (k = 7; k >= 0; k--) begin
      sdi_i <= d1[k];
      sck_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("sdo", d2[k], sdo_o);
      sck_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    byte_end();
    rdr(`SSP_OFF_STAT); chk("bf_rx", 32'h01, rd);
    rdr(`SSP_OFF_BUF); chk("rx_buf", d1, rd);
    rdr(`SSP_OFF_STAT); chk("bf_read", 32'h00, rd);
    chk("pins", 0, {scl_o, sda_o});
    rdr(`SSP_OFF_IRQ_STAT); chk("cleared", 32'h00, rd);
    stop_test();
  end
endmodule
`default_nettype wire

// ==== dv/ssp_i2c_slave_model.sv ====
/*
 Behavioural I2C slave beside the transmitter: samples SDA on SCL rise,
 answers the ninth clock. Assumes open-drain wires with pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none

module ssp_i2c_slave_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ack_en_i,
  output logic            sda_low_o,
  output logic [7:0]      rx_byte_o,
  output logic            stable_err_o
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] nbits;

  // Edge detection on the system clock; a released line reads as pull-up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nbits <= 4'h0;
      sda_low_o <= 1'b0;
      rx_byte_o <= 8'h00;
      stable_err_o <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (scl_i && !scl_q) begin
        if (nbits < 4'h8) rx_byte_o <= {rx_byte_o[6:0], sda_i};
        nbits <= nbits + 4'h1;
      end
      // Data must not move while the clock is high
      if (scl_i && scl_q && (sda_i != sda_q)) stable_err_o <= 1'b1;
      if (!scl_i && scl_q) begin
        if (nbits == 4'h8) sda_low_o <= ack_en_i;
        else begin
          sda_low_o <= 1'b0;
          if (nbits == 4'h9) nbits <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== pkg/ssp_cfg.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 serial port block. Assumes a 25 MHz system clock and a 32-bit AXI4-Lite bus.
*/
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

`define SSP_OFF_CTRL1      8'h00
`define SSP_OFF_STAT       8'h04
`define SSP_OFF_BUF        8'h08
`define SSP_OFF_CTRL2      8'h0C
`define SSP_OFF_BRG        8'h10
`define SSP_OFF_IRQ_STAT   8'h14
`define SSP_OFF_IRQ_MASK   8'h18

`define SSP_CTRL1_MODE_BIT 0
`define SSP_CTRL1_CKP_BIT  4
`define SSP_STAT_SMP_BIT   7
`define SSP_STAT_CKE_BIT   6
`define SSP_STAT_BF_BIT    0
`define SSP_CTRL2_ACK_BIT  6
`define SSP_IRQ_SER_BIT    0
`define SSP_IRQ_WRITE_COLLISION_FLAG_BIT   1

`define SSP_BRG_RST        8'h09
`define SSP_I2C_LAST_BIT   4'h7
`define SSP_I2C_ACK_BIT    4'h8
`define SSP_SPI_LAST_BIT   4'h7

`define SSP_RESP_OKAY      2'h0
`define SSP_RESP_SLVERR    2'h2

// Clock period and instruction cycle, in ns
`define SSP_CLK_NS         40
`define SSP_TCY_NS         160
`define SSP_COLL_WIN_TCY   2
// Longest time: rounded down to whole clock cycles
`define SSP_COLL_WIN_CYC   ((`SSP_COLL_WIN_TCY * `SSP_TCY_NS) / `SSP_CLK_NS)

`endif

// ==== pkg/ssp_pkg.sv ====
/*
 Types of the serial port block. Assumes the constants of ssp_cfg.svh.
*/
package ssp_pkg;
  // Byte-level state of the I2C transmit sequencer
  typedef enum logic [3:0] {
    SSP_ST_IDLE = 4'h1,
    SSP_ST_LOW  = 4'h2,
    SSP_ST_HIGH = 4'h4,
    SSP_ST_HOLD = 4'h8
  } ssp_state_e;
endpackage

// ==== verilog/ssp_brg.sv ====
/*
 Baud-rate generator: a reloading down-counter that pulses once per period.
 Assumes run_i and period_i come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ssp_brg #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] period_i,
  output logic              roll_o
);
  logic [W-1:0] cnt;

  if (W < 2) $error("ssp_brg: W must be at least 2");

  // Reload while stopped, so every start gives a full period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      roll_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt    <= period_i - W'(1);
        roll_o <= 1'b0;
      end else if (cnt == '0) begin
        cnt    <= period_i - W'(1);
        roll_o <= 1'b1;
      end else begin
        cnt    <= cnt - W'(1);
        roll_o <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_brg_reload: assert property (ce_i && run_i && cnt == '0 |=> cnt == $past(period_i) - W'(1))
    else $error("brg did not reload from period");
endmodule

`default_nettype wire

// ==== verilog/ssp_i2c_master_tx.sv ====
/*
 Serial port: I2C master byte transmitter, SPI slave shift path, status and
 control registers on an AXI4-Lite slave, sticky interrupt flags.
 Assumes start/stop conditions are made elsewhere; pins are open drain
 (scl/sda) with external pull-ups; sck_i/sdi_i come from an SPI master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssp_cfg.svh"

module ssp_i2c_master_tx #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned BRG_W  = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              sck_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  output logic                   irq_o
);
  localparam int unsigned WIN_W = 4;
  localparam logic [WIN_W-1:0] WIN_CYC = WIN_W'(`SSP_COLL_WIN_CYC);

  if (ADDR_W < 8) $error("ssp_i2c_master_tx: ADDR_W must be at least 8");
  if (BRG_W < 2 || BRG_W > 8) $error("ssp_i2c_master_tx: BRG_W must be 2..8");
  if (`SSP_COLL_WIN_CYC < 1 || `SSP_COLL_WIN_CYC > 15) $error("window does not fit");

  logic                   mode_spi;
  logic                   clock_idle_polarity;
  logic                   sample_phase_select;
  logic                   clock_edge_select;
  logic                   buffer_full_flag;
  logic                   ack_received_status;
  logic [7:0]             serial_buffer;
  logic [7:0]             shift_stage;
  logic [BRG_W-1:0]       brg_period;
  logic [1:0]             irq_status;
  logic [1:0]             irq_mask;
  ssp_pkg::ssp_state_e    state;
  logic [3:0]             bit_cnt;
  logic [3:0]             spi_cnt;
  logic                   drive_pend;
  logic [WIN_W-1:0]       win_cnt;
  logic [3:0]             pin_raw;
  logic [3:0]             pin_sync;
  logic                   sck_d;
  logic                   roll;
  logic                   brg_run;
  logic                   wr_fire;
  logic                   wr_lo;
  logic                   wr_hit;
  logic                   wr_buf;
  logic                   rd_fire;
  logic                   rd_hit;
  logic [7:0]             rd_val;
  logic                   busy;
  logic                   buf_accept;
  logic                   buf_late;
  logic                   buf_drop;
  logic                   buf_load;
  logic                   fall_ev;
  logic                   ack_ev;
  logic                   sck_chg;
  logic                   idle_edge;
  logic                   act_edge;
  logic                   spi_smp;
  logic                   spi_tx;
  logic                   spi_done;

  // Pin synchronisers: index 3 sck, 2 sdi, 1 scl, 0 sda
  assign pin_raw = {sck_i, sdi_i, scl_i, sda_i};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    logic meta;
    logic sync;
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        meta <= 1'b0;
        sync <= 1'b0;
      end else if (ce_i) begin
        meta <= pin_raw[i];
        sync <= meta;
      end
    end
    assign pin_sync[i] = sync;
  end

  // Bus handshakes and buffer write classification
  assign wr_fire    = s_axi_awready_o & s_axi_awvalid_i & s_axi_wvalid_i;
  assign wr_lo      = wr_fire & s_axi_wstrb_i[0];
  assign rd_fire    = s_axi_arready_o & s_axi_arvalid_i;
  assign wr_buf     = wr_lo & (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_BUF));
  assign busy       = (state == ssp_pkg::SSP_ST_LOW) | (state == ssp_pkg::SSP_ST_HIGH)
                    | (spi_cnt != 4'h0);
  assign buf_accept = wr_buf & ~busy;
  assign buf_late   = wr_buf & busy & (win_cnt != '0);
  assign buf_drop   = wr_buf & busy & (win_cnt == '0);
  assign buf_load   = buf_accept | buf_late;

  // I2C bit events on generator rollover
  assign brg_run = (state == ssp_pkg::SSP_ST_LOW)
                 | ((state == ssp_pkg::SSP_ST_HIGH) & pin_sync[1]);
  assign fall_ev = (state == ssp_pkg::SSP_ST_HIGH) & roll;
  assign ack_ev  = fall_ev & (bit_cnt == `SSP_I2C_ACK_BIT);

  // SPI edges relative to the idle clock level
  assign sck_chg   = pin_sync[3] ^ sck_d;
  assign idle_edge = sck_chg & (pin_sync[3] == clock_idle_polarity);
  assign act_edge  = sck_chg & (pin_sync[3] != clock_idle_polarity);
  assign spi_tx    = mode_spi & (clock_edge_select ? idle_edge : act_edge);
  assign spi_smp   = mode_spi & (clock_edge_select ? act_edge : idle_edge);
  assign spi_done  = spi_smp & (spi_cnt == `SSP_SPI_LAST_BIT);

  ssp_brg #(
    .W (BRG_W)
  ) u_brg (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .ce_i     (ce_i),
    .run_i    (brg_run),
    .period_i (brg_period),
    .roll_o   (roll)
  );

  // Write decode; the shift stage has no address
  always_comb begin
    wr_hit = 1'b0;
    if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_CTRL1)) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_STAT)) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_BUF)) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_CTRL2)) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_BRG)) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_IRQ_STAT)) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_IRQ_MASK)) begin
      wr_hit = 1'b1;
    end
  end

  // Read mux; unmapped reads answer zero with an error
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_CTRL1)) begin
      rd_val[`SSP_CTRL1_MODE_BIT] = mode_spi;
      rd_val[`SSP_CTRL1_CKP_BIT]  = clock_idle_polarity;
    end else if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_STAT)) begin
      rd_val[`SSP_STAT_SMP_BIT] = sample_phase_select;
      rd_val[`SSP_STAT_CKE_BIT] = clock_edge_select;
      rd_val[`SSP_STAT_BF_BIT]  = buffer_full_flag;
    end else if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_BUF)) begin
      rd_val = serial_buffer;
    end else if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_CTRL2)) begin
      rd_val[`SSP_CTRL2_ACK_BIT] = ack_received_status;
    end else if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_BRG)) begin
      rd_val = 8'(brg_period);
    end else if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_IRQ_STAT)) begin
      rd_val = {6'h00, irq_status};
    end else if (s_axi_araddr_i == ADDR_W'(`SSP_OFF_IRQ_MASK)) begin
      rd_val = {6'h00, irq_mask};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // AXI4-Lite handshakes: address and data are taken together
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `SSP_RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= `SSP_RESP_OKAY;
      s_axi_rdata_o   <= 32'h00000000;
    end else if (ce_i) begin
      s_axi_awready_o <= s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_awready_o & ~s_axi_bvalid_o;
      s_axi_wready_o  <= s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_awready_o & ~s_axi_bvalid_o;
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      s_axi_arready_o <= s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
      if (rd_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= {24'h000000, rd_val};
        s_axi_rresp_o  <= rd_hit ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Software-writable control fields; status keeps its low six bits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_spi            <= 1'b0;
      clock_idle_polarity <= 1'b0;
      sample_phase_select <= 1'b0;
      clock_edge_select   <= 1'b0;
      brg_period          <= BRG_W'(`SSP_BRG_RST);
      irq_mask            <= 2'h0;
    end else if (ce_i && wr_lo) begin
      if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_CTRL1)) begin
        mode_spi            <= s_axi_wdata_i[`SSP_CTRL1_MODE_BIT];
        clock_idle_polarity <= s_axi_wdata_i[`SSP_CTRL1_CKP_BIT];
      end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_STAT)) begin
        sample_phase_select <= s_axi_wdata_i[`SSP_STAT_SMP_BIT];
        clock_edge_select   <= s_axi_wdata_i[`SSP_STAT_CKE_BIT];
      end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_BRG)) begin
        brg_period <= s_axi_wdata_i[BRG_W-1:0];
      end else if (s_axi_awaddr_i == ADDR_W'(`SSP_OFF_IRQ_MASK)) begin
        irq_mask <= s_axi_wdata_i[1:0];
      end
    end
  end

  // Shift stage: loaded with the buffer, shifted by either link
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_stage <= 8'h00;
    end else if (ce_i) begin
      if (buf_load) begin
        shift_stage <= s_axi_wdata_i[7:0];
      end else if (spi_smp) begin
        shift_stage <= {shift_stage[6:0], pin_sync[2]};
      end else if (fall_ev && bit_cnt < `SSP_I2C_ACK_BIT) begin
        shift_stage <= {shift_stage[6:0], 1'b0};
      end
    end
  end

  // Buffer: late rewrite still lands, which may corrupt the byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      serial_buffer <= 8'h00;
    end else if (ce_i) begin
      if (buf_load) begin
        serial_buffer <= s_axi_wdata_i[7:0];
      end else if (spi_done) begin
        serial_buffer <= {shift_stage[6:0], pin_sync[2]};
      end
    end
  end

  // Buffer full: set wins over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buffer_full_flag <= 1'b0;
    end else if (ce_i) begin
      if ((buf_load && !mode_spi) || spi_done) begin
        buffer_full_flag <= 1'b1;
      end else if (fall_ev && bit_cnt == `SSP_I2C_LAST_BIT) begin
        buffer_full_flag <= 1'b0;
      end else if (rd_fire && mode_spi && s_axi_araddr_i == ADDR_W'(`SSP_OFF_BUF)) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // Collision window after an accepted write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      win_cnt <= '0;
    end else if (ce_i) begin
      if (buf_accept) begin
        win_cnt <= WIN_CYC;
      end else if (win_cnt != '0) begin
        win_cnt <= win_cnt - WIN_W'(1);
      end
    end
  end

  // I2C byte sequencer; SDA changes one clock after SCL falls for hold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state      <= ssp_pkg::SSP_ST_IDLE;
      bit_cnt    <= 4'h0;
      drive_pend <= 1'b0;
      scl_oe_o   <= 1'b0;
      sda_oe_o   <= 1'b0;
      scl_o      <= 1'b0;
      sda_o      <= 1'b0;
    end else if (ce_i) begin
      scl_o      <= 1'b0;
      sda_o      <= 1'b0;
      drive_pend <= 1'b0;
      if (drive_pend) begin
        sda_oe_o <= (bit_cnt < `SSP_I2C_ACK_BIT) & ~shift_stage[7];
      end
      case (state)
        ssp_pkg::SSP_ST_IDLE, ssp_pkg::SSP_ST_HOLD: begin
          if (buf_accept && !mode_spi) begin
            state      <= ssp_pkg::SSP_ST_LOW;
            bit_cnt    <= 4'h0;
            scl_oe_o   <= 1'b1;
            drive_pend <= 1'b1;
          end
        end
        ssp_pkg::SSP_ST_LOW: begin
          if (roll) begin
            state    <= ssp_pkg::SSP_ST_HIGH;
            scl_oe_o <= 1'b0;
          end
        end
        ssp_pkg::SSP_ST_HIGH: begin
          if (roll) begin
            scl_oe_o <= 1'b1;
            if (bit_cnt == `SSP_I2C_ACK_BIT) begin
              state <= ssp_pkg::SSP_ST_HOLD;
            end else begin
              state      <= ssp_pkg::SSP_ST_LOW;
              bit_cnt    <= bit_cnt + 4'h1;
              drive_pend <= 1'b1;
            end
          end
        end
        default: begin
          state <= ssp_pkg::SSP_ST_IDLE;
        end
      endcase
    end
  end

  // Acknowledge captured on the ninth falling edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_received_status <= 1'b0;
    end else if (ce_i && ack_ev) begin
      ack_received_status <= pin_sync[0];
    end
  end

  // SPI bit counter and transmit pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      spi_cnt <= 4'h0;
      sck_d   <= 1'b0;
      sdo_o   <= 1'b0;
    end else if (ce_i) begin
      sck_d <= pin_sync[3];
      if (!mode_spi) begin
        spi_cnt <= 4'h0;
      end else if (spi_smp) begin
        spi_cnt <= spi_done ? 4'h0 : spi_cnt + 4'h1;
      end
      if (buf_load && mode_spi) begin
        sdo_o <= s_axi_wdata_i[7];
      end else if (spi_tx) begin
        sdo_o <= shift_stage[7];
      end
    end
  end

  // Sticky events, cleared by writing one; hardware never clears them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_status <= 2'h0;
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      for (int b = 0; b < 2; b++) begin
        if ((b == `SSP_IRQ_SER_BIT && (ack_ev || spi_done)) ||
            (b == `SSP_IRQ_WRITE_COLLISION_FLAG_BIT && (buf_late || buf_drop))) begin
          irq_status[b] <= 1'b1;
        end else if (wr_lo && s_axi_awaddr_i == ADDR_W'(`SSP_OFF_IRQ_STAT) &&
                     s_axi_wdata_i[b]) begin
          irq_status[b] <= 1'b0;
        end
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_write_collision_flag_on_busy: assert property (ce_i && wr_buf && busy |=> irq_status[`SSP_IRQ_WRITE_COLLISION_FLAG_BIT])
    else $error("collision flag not set");
  a_drop_keeps_buf: assert property (ce_i && buf_drop && !spi_done |=> $stable(serial_buffer))
    else $error("dropped write changed buffer");
  a_late_updates_buf: assert property (ce_i && buf_late |=> serial_buffer == $past(s_axi_wdata_i[7:0]))
    else $error("late rewrite not stored");
  a_write_loads_both: assert property (ce_i && buf_load |=> shift_stage == serial_buffer)
    else $error("shift stage differs from buffer");
  a_bf_after_write: assert property (ce_i && buf_accept && !mode_spi |=> buffer_full_flag)
    else $error("buffer full not set");
  a_hold_scl_low: assert property (state == ssp_pkg::SSP_ST_HOLD |-> scl_oe_o && !drive_pend)
    else $error("SCL released while held");
  a_ack_captured: assert property (ce_i && ack_ev |=> ack_received_status == $past(pin_sync[0]))
    else $error("acknowledge not captured");
  a_sda_stable_high: assert property (state == ssp_pkg::SSP_ST_HIGH && $past(state) == ssp_pkg::SSP_ST_HIGH |-> $stable(sda_oe_o))
    else $error("SDA moved while SCL high");
  a_release_eighth: assert property (ce_i && fall_ev && bit_cnt == `SSP_I2C_LAST_BIT |=> ##1 !sda_oe_o)
    else $error("SDA not released for acknowledge");
  a_start_byte: assert property (ce_i && buf_accept && !mode_spi |=> state == ssp_pkg::SSP_ST_LOW && scl_oe_o)
    else $error("byte did not start");
  a_spi_byte_done: assert property (ce_i && spi_done |=> buffer_full_flag && irq_status[`SSP_IRQ_SER_BIT])
    else $error("received byte not posted");

  c_full_byte: cover property (state == ssp_pkg::SSP_ST_HIGH ##1 state == ssp_pkg::SSP_ST_HOLD);
  c_late_rewrite: cover property (ce_i && buf_late);
  c_spi_byte: cover property (ce_i && spi_done);
endmodule

`default_nettype wire
